// [rtl/adcrb_register_bank.v]
// Control and status register bank of the eight-channel audio converter
`timescale 1ns/1ps
`include "adcrb_defines.vh"

module adcrb_register_bank #(
  parameter [3:0] PART_IDENT = 4'h5,   // Arbitrary identification value
  parameter [3:0] REV_INDEX  = 4'h2    // Arbitrary revision value
) (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       ptr_load,
  input  wire [7:0] ptr_data,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire       rd_en,
  input  wire [7:0] ovf_detect,
  input  wire       pin_clock_ratio,
  input  wire [1:0] pin_divider_bits,
  input  wire [1:0] pin_format,
  input  wire [1:0] pin_mode,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg  [2:0] clock_div_sel,
  output reg  [1:0] serial_format_field,
  output reg  [1:0] speed_role,
  output reg  [7:0] highpass_off,
  output reg  [7:0] dc_offset_freeze,
  output reg        bandgap_off,
  output reg        oscillator_off,
  output reg  [3:0] pair_power_off,
  output reg  [7:0] channel_zero,
  output reg  [3:0] serial_out_disable,
  output reg        overflow_pin_out,
  output reg        overflow_pin_oe
);

  localparam CHANNELS = 8;
  localparam PAIRS    = 4;

  reg  [7:0] global_control_reg;
  reg  [7:0] overflow_flag_reg;
  reg  [7:0] overflow_pin_enable_reg;
  reg  [7:0] highpass_reg;
  reg  [7:0] power_reg;
  reg  [7:0] silence_reg;
  reg  [7:0] tristate_reg;
  reg  [6:0] ptr_reg;
  reg        pointer_autoinc_reg;
  reg  [7:0] rd_mux;
  reg  [2:0] div_code;
  reg  [1:0] format_sel;
  reg  [1:0] mode_sel;
  wire [7:0] overflow_flag_next;
  wire [7:0] pin_pull;
  wire [7:0] pair_zero;
  wire [7:0] silence_sel;
  wire [7:0] highpass_sel;
  wire [3:0] pair_off_sel;
  wire [3:0] tristate_sel;
  wire [7:0] wr_bits;
  wire       takeover;
  wire       acc_byte;
  wire       flag_read;
  wire       wr_global;
  wire       wr_mask;
  wire       wr_highpass;
  wire       wr_power;
  wire       wr_silence;
  wire       wr_tristate;

  // Composite divider decode: {ratio, div_hi, div_lo}
  function [2:0] div_decode;
    input [2:0] code;
    begin
      case (code)
        3'b000:         div_decode = `ADCRB_DIV_BY1;
        3'b100:         div_decode = `ADCRB_DIV_BY1P5;
        3'b001, 3'b010: div_decode = `ADCRB_DIV_BY2;
        3'b101, 3'b110: div_decode = `ADCRB_DIV_BY3;
        3'b011:         div_decode = `ADCRB_DIV_BY4;
        default:        div_decode = `ADCRB_DIV_RSVD;
      endcase
    end
  endfunction

  // Bits that a host write may change at each address
  function [7:0] writable_bits;
    input [6:0] addr;
    begin
      if (addr == `ADCRB_ADDR_GLOBAL) begin
        writable_bits = 8'hff;
      end else if (addr == `ADCRB_ADDR_OVF_MASK) begin
        writable_bits = 8'hff;
      end else if (addr == `ADCRB_ADDR_HIGHPASS) begin
        writable_bits = 8'hff;
      end else if (addr == `ADCRB_ADDR_POWER) begin
        writable_bits = `ADCRB_PD_MASK;
      end else if (addr == `ADCRB_ADDR_SILENCE) begin
        writable_bits = 8'hff;
      end else if (addr == `ADCRB_ADDR_SER_TRI) begin
        writable_bits = `ADCRB_TRI_MASK;
      end else begin
        writable_bits = 8'h00;
      end
    end
  endfunction

  // Access strobes
  assign takeover    = global_control_reg[`ADCRB_GC_TAKEOVER];
  assign acc_byte    = wr_en | rd_en;
  assign flag_read   = rd_en & (ptr_reg == `ADCRB_ADDR_OVF_FLAGS);
  assign wr_bits     = wr_data & writable_bits(ptr_reg);
  assign wr_global   = wr_en & (ptr_reg == `ADCRB_ADDR_GLOBAL);
  assign wr_mask     = wr_en & (ptr_reg == `ADCRB_ADDR_OVF_MASK);
  assign wr_highpass = wr_en & (ptr_reg == `ADCRB_ADDR_HIGHPASS);
  assign wr_power    = wr_en & (ptr_reg == `ADCRB_ADDR_POWER);
  assign wr_silence  = wr_en & (ptr_reg == `ADCRB_ADDR_SILENCE);
  assign wr_tristate = wr_en & (ptr_reg == `ADCRB_ADDR_SER_TRI);

  // Read multiplexer
  always @* begin
    rd_mux = 8'h00;
    if (ptr_reg == `ADCRB_ADDR_IDENT) begin
      rd_mux = {PART_IDENT, REV_INDEX};
    end else if (ptr_reg == `ADCRB_ADDR_GLOBAL) begin
      rd_mux = global_control_reg;
    end else if (ptr_reg == `ADCRB_ADDR_OVF_FLAGS) begin
      rd_mux = overflow_flag_reg;
    end else if (ptr_reg == `ADCRB_ADDR_OVF_MASK) begin
      rd_mux = overflow_pin_enable_reg;
    end else if (ptr_reg == `ADCRB_ADDR_HIGHPASS) begin
      rd_mux = highpass_reg;
    end else if (ptr_reg == `ADCRB_ADDR_POWER) begin
      rd_mux = power_reg;
    end else if (ptr_reg == `ADCRB_ADDR_SILENCE) begin
      rd_mux = silence_reg;
    end else if (ptr_reg == `ADCRB_ADDR_SER_TRI) begin
      rd_mux = tristate_reg;
    end
  end

  // Per-channel and per-pair terms
  genvar ch;
  genvar pr;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      // A new overflow keeps the flag low even in the cycle of a rearming read
      assign overflow_flag_next[ch] = ovf_detect[ch] ? 1'b0 :
                                      (flag_read | overflow_flag_reg[ch]);
      assign pin_pull[ch]     = ~overflow_flag_next[ch] & overflow_pin_enable_reg[ch];
      assign pair_zero[ch]    = pair_off_sel[ch / 2];
      assign silence_sel[ch]  = takeover & silence_reg[ch];
      assign highpass_sel[ch] = takeover & highpass_reg[ch];
    end
    for (pr = 0; pr < PAIRS; pr = pr + 1) begin : g_pair
      assign pair_off_sel[pr] = takeover & power_reg[`ADCRB_PD_PAIR_LO + pr];
      assign tristate_sel[pr] = takeover & tristate_reg[pr];
    end
  endgenerate

  // Effective mode: pins until takeover, register fields after
  always @* begin
    if (takeover) begin
      div_code   = global_control_reg[`ADCRB_GC_RATIO:`ADCRB_GC_DIV_LO];
      format_sel = global_control_reg[`ADCRB_GC_FMT_HI:`ADCRB_GC_FMT_LO];
      mode_sel   = global_control_reg[`ADCRB_GC_MODE_HI:`ADCRB_GC_MODE_LO];
    end else begin
      div_code   = {pin_clock_ratio, pin_divider_bits};
      format_sel = pin_format;
      mode_sel   = pin_mode;
    end
  end

  // Read answer one cycle after the request, byte held until the next read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_mux;
      end
    end
  end

  // Address pointer; a load wins over auto-increment
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_reg             <= `ADCRB_RST_PTR;
      pointer_autoinc_reg <= 1'b0;
    end else if (ptr_load) begin
      ptr_reg             <= ptr_data[6:0];
      pointer_autoinc_reg <= ptr_data[`ADCRB_MAP_AUTOINC];
    end else if (acc_byte && pointer_autoinc_reg) begin
      ptr_reg <= ptr_reg + 7'h01;
    end
  end

  // Writable registers; reserved bits and addresses take nothing
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      global_control_reg      <= `ADCRB_RST_GLOBAL;
      overflow_pin_enable_reg <= `ADCRB_RST_OVF_MASK;
      highpass_reg            <= `ADCRB_RST_HIGHPASS;
      power_reg               <= `ADCRB_RST_POWER;
      silence_reg             <= `ADCRB_RST_SILENCE;
      tristate_reg            <= `ADCRB_RST_SER_TRI;
    end else begin
      if (wr_global) begin
        global_control_reg <= wr_bits;
      end
      if (wr_mask) begin
        overflow_pin_enable_reg <= wr_bits;
      end
      if (wr_highpass) begin
        highpass_reg <= wr_bits;
      end
      if (wr_power) begin
        power_reg <= wr_bits;
      end
      if (wr_silence) begin
        silence_reg <= wr_bits;
      end
      if (wr_tristate) begin
        tristate_reg <= wr_bits;
      end
    end
  end

  // Sticky active-low overflow flags
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag_reg <= `ADCRB_RST_OVF_FLAGS;
    end else begin
      overflow_flag_reg <= overflow_flag_next;
    end
  end

  // Clock and serial format outputs
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_div_sel       <= `ADCRB_DIV_BY1;
      serial_format_field <= 2'h0;
      speed_role          <= 2'h0;
    end else begin
      clock_div_sel       <= div_decode(div_code);
      serial_format_field <= format_sel;
      speed_role          <= mode_sel;
    end
  end

  // Per-channel filter and data forcing outputs
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      highpass_off     <= 8'h00;
      dc_offset_freeze <= 8'h00;
      channel_zero     <= 8'h00;
    end else begin
      highpass_off     <= highpass_sel;
      dc_offset_freeze <= highpass_sel;
      channel_zero     <= pair_zero | silence_sel;
    end
  end

  // Power-down and serial output disable outputs
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bandgap_off        <= 1'b0;
      oscillator_off     <= 1'b0;
      pair_power_off     <= 4'h0;
      serial_out_disable <= 4'h0;
    end else begin
      bandgap_off        <= takeover & power_reg[`ADCRB_PD_BANDGAP];
      oscillator_off     <= takeover & power_reg[`ADCRB_PD_OSC];
      pair_power_off     <= pair_off_sel;
      serial_out_disable <= tristate_sel;
    end
  end

  // Open-drain overflow pin: enable pulls low while any unmasked flag is asserted
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_pin_out <= 1'b0;
      overflow_pin_oe  <= 1'b0;
    end else begin
      overflow_pin_out <= 1'b0;
      overflow_pin_oe  <= |pin_pull;
    end
  end

endmodule // adcrb_register_bank

// [rtl/adcrb_defines.vh]
// Register offsets, field positions and reset values of the converter register bank
`ifndef ADCRB_DEFINES_VH
`define ADCRB_DEFINES_VH

`define ADCRB_ADDR_IDENT        7'h00
`define ADCRB_ADDR_GLOBAL       7'h01
`define ADCRB_ADDR_OVF_FLAGS    7'h02
`define ADCRB_ADDR_OVF_MASK     7'h03
`define ADCRB_ADDR_HIGHPASS     7'h04
`define ADCRB_ADDR_POWER        7'h06
`define ADCRB_ADDR_SILENCE      7'h08
`define ADCRB_ADDR_SER_TRI      7'h0a

`define ADCRB_RST_GLOBAL        8'h00
`define ADCRB_RST_OVF_FLAGS     8'hff
`define ADCRB_RST_OVF_MASK      8'hff
`define ADCRB_RST_HIGHPASS      8'h00
`define ADCRB_RST_POWER         8'h00
`define ADCRB_RST_SILENCE       8'h00
`define ADCRB_RST_SER_TRI       8'h00
`define ADCRB_RST_PTR           7'h00

`define ADCRB_GC_TAKEOVER       7
`define ADCRB_GC_RATIO          6
`define ADCRB_GC_DIV_HI         5
`define ADCRB_GC_DIV_LO         4
`define ADCRB_GC_FMT_HI         3
`define ADCRB_GC_FMT_LO         2
`define ADCRB_GC_MODE_HI        1
`define ADCRB_GC_MODE_LO        0

`define ADCRB_PD_BANDGAP        5
`define ADCRB_PD_OSC            4
`define ADCRB_PD_PAIR_HI        3
`define ADCRB_PD_PAIR_LO        0
`define ADCRB_PD_MASK           8'h3f
`define ADCRB_TRI_MASK          8'h0f

`define ADCRB_MAP_AUTOINC       7

`define ADCRB_DIV_BY1           3'h0
`define ADCRB_DIV_BY1P5         3'h1
`define ADCRB_DIV_BY2           3'h2
`define ADCRB_DIV_BY3           3'h3
`define ADCRB_DIV_BY4           3'h4
`define ADCRB_DIV_RSVD          3'h7

`endif

// [tb/adcrb_asserts.sv]
// Port checker for the converter register bank
`timescale 1ns/1ps
module adcrb_asserts (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] ovf_detect,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic [2:0] clock_div_sel,
  input wire logic [7:0] highpass_off,
  input wire logic [7:0] dc_offset_freeze,
  input wire logic [3:0] pair_power_off,
  input wire logic [7:0] channel_zero,
  input wire logic       overflow_pin_out,
  input wire logic       overflow_pin_oe
);
  logic [1:0] up;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) up <= 2'd0;
    else if (up != 2'd2) up <= up + 2'd1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (rd_en |=> rd_valid) else $error("read answer missing");
  a_no_stray: assert property (!rd_en |=> !rd_valid) else $error("stray read answer");
  a_rdata_hold: assert property (up == 2'd2 && !rd_valid |-> $stable(rd_data))
    else $error("read byte moved");
  a_pin_out_low: assert property (overflow_pin_out == 1'b0) else $error("pin level");
  a_pin_rise_cause: assert property (up == 2'd2 && $rose(overflow_pin_oe) |->
    $past(ovf_detect) != 8'h00 || $past(wr_en, 2)) else $error("pin rose alone");
  a_pin_fall_cause: assert property (up == 2'd2 && $fell(overflow_pin_oe) |->
    $past(rd_en) || $past(wr_en, 2)) else $error("pin fell alone");
  a_pair_zeroes: assert property (&(channel_zero | ~{{2{pair_power_off[3]}},
    {2{pair_power_off[2]}}, {2{pair_power_off[1]}}, {2{pair_power_off[0]}}}))
    else $error("pair not zeroed");
  a_freeze_follow: assert property ($rose(highpass_off[0]) |-> ##[0:1] dc_offset_freeze[0])
    else $error("offset not frozen");
  a_div_code: assert property (clock_div_sel != 3'h5 && clock_div_sel != 3'h6)
    else $error("bad divider code");
  c_flag_read: cover property (rd_valid && rd_data == 8'hf6);
  c_pin_rise: cover property ($rose(overflow_pin_oe));
  c_div_rsvd: cover property (clock_div_sel == 3'h7);
endmodule // adcrb_asserts

// [tb/adcrb_host.sv]
// Host model driving the register port of the bank
`timescale 1ns/1ps
module adcrb_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            ptr_load = 1'b0,
  output logic [7:0]      ptr_data = 8'h00,
  output logic            wr_en = 1'b0,
  output logic [7:0]      wr_data = 8'h00,
  output logic            rd_en = 1'b0
);
  task automatic point(input logic [7:0] a);
    @(negedge ref_clk);
    ptr_load = 1'b1;
    ptr_data = a;
    @(negedge ref_clk);
    ptr_load = 1'b0;
    ptr_data = ~a;
  endtask
  task automatic wr(input logic [7:0] d);
    wr_en = 1'b1;
    wr_data = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
  task automatic get(output logic [7:0] d, output logic ok);
    @(negedge ref_clk);
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    d = rd_data;
    ok = rd_valid;
  endtask
endmodule // adcrb_host

// [tb/adc_control_register_bank_tb.sv]
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
module adc_control_register_bank_tb;
  logic       ref_clk = 1'b0, nrst = 1'b0, pin_clock_ratio = 1'b1, ok;
  logic [1:0] pin_divider_bits = 2'b11, pin_format = 2'b10, pin_mode = 2'b11;
  logic [7:0] ovf_detect = 8'h00, d, rd_data, ptr_data, wr_data, highpass_off;
  logic [7:0] dc_offset_freeze, channel_zero;
  logic       ptr_load, wr_en, rd_en, rd_valid, bandgap_off, oscillator_off;
  logic       overflow_pin_out, overflow_pin_oe;
  logic [1:0] serial_format_field, speed_role;
  logic [2:0] clock_div_sel;
  logic [3:0] pair_power_off, serial_out_disable;
  int         n_errors = 0, total_checks = 0, cyc = 0;
  logic [2:0] divs [8] = '{3'h0, 3'h2, 3'h2, 3'h4, 3'h1, 3'h3, 3'h3, 3'h7};
  logic [31:0] rows [13] = '{32'h0032_ff32, 32'h02ff_00ff, 32'h0100_a5a5, 32'h03ff_5a5a,
    32'h0400_3d3d, 32'h0500_ff00, 32'h0600_ff3f, 32'h0700_ff00, 32'h0800_c3c3,
    32'h0900_ff00, 32'h0a00_ff0f, 32'h0b00_ff00, 32'h7f00_ff00};
  adcrb_register_bank #(.PART_IDENT(4'h3), .REV_INDEX(4'h2)) uut (.*);
  adcrb_host host (.*);
  always #4 ref_clk = ~ref_clk;
  task stop_test;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    host.point(a);
    host.get(d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask
  task pulse(input logic [7:0] v, input logic oe);
    @(negedge ref_clk);
    ovf_detect = v;
    @(negedge ref_clk);
    ovf_detect = 8'h00;
    chk({7'h00, overflow_pin_oe}, {7'h00, oe});
    chk({7'h00, overflow_pin_out}, 8'h00);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      rdchk(rows[i][31:24], rows[i][23:16]);
      host.point(rows[i][31:24]);
      host.wr(rows[i][15:8]);
      rdchk(rows[i][31:24], rows[i][7:0]);
    end
    chk({5'h00, clock_div_sel}, 8'h02);
    chk({4'h0, serial_format_field, speed_role}, 8'h05);
    chk({bandgap_off, oscillator_off, 2'h0, pair_power_off}, 8'hcf);
    chk(channel_zero, 8'hff);
    chk(highpass_off, 8'h3d);
    chk({4'h0, serial_out_disable}, 8'h0f);
    chk(dc_offset_freeze, 8'h3d);
    host.point(8'h06);
    host.wr(8'h05);
    repeat (2) @(negedge ref_clk);
    chk({bandgap_off, oscillator_off, 2'h0, pair_power_off}, 8'h05);
    chk(channel_zero, 8'hf3);
    for (int c = 0; c < 8; c++) begin
      host.point(8'h01);
      host.wr({1'b1, c[2:0], c[1:0], c[1:0]});
      repeat (2) @(negedge ref_clk);
      chk({5'h00, clock_div_sel}, {5'h00, divs[c]});
      chk({4'h0, serial_format_field, speed_role}, {4'h0, c[1:0], c[1:0]});
    end
    host.point(8'h01);
    host.wr(8'h00);
    repeat (2) @(negedge ref_clk);
    chk({5'h00, clock_div_sel}, 8'h07);
    chk({4'h0, serial_format_field, speed_role}, 8'h0b);
    chk(highpass_off, 8'h00);
    pin_clock_ratio = 1'b0;
    pin_divider_bits = 2'b01;
    pin_format = 2'b01;
    pin_mode = 2'b10;
    repeat (2) @(negedge ref_clk);
    chk({5'h00, clock_div_sel}, 8'h02);
    chk({4'h0, serial_format_field, speed_role}, 8'h06);
    host.point(8'h83);
    host.get(d, ok);
    chk(d, 8'h5a);
    host.get(d, ok);
    chk(d, 8'h3d);
    pulse(8'h01, 1'b0);
    pulse(8'h08, 1'b1);
    rdchk(8'h02, 8'hf6);
    chk({7'h00, overflow_pin_oe}, 8'h00);
    rdchk(8'h02, 8'hff);
    ovf_detect = 8'h08;
    rdchk(8'h02, 8'hf7);
    ovf_detect = 8'h00;
    rdchk(8'h02, 8'hf7);
    rdchk(8'h02, 8'hff);
    nrst = 1'b0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    rdchk(8'h01, 8'h00);
    rdchk(8'h03, 8'hff);
    stop_test;
  end
endmodule // adc_control_register_bank_tb
bind adcrb_register_bank adcrb_asserts chk_i (.*);
